// ===== rtl/pmdp_data_port.sv
`timescale 1ns/1ns
`include "pmdp_regs.svh"

module pmdp_data_port (
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  input  wire pmdp_pkg::pmdp_mode_e  mode_i,
  input  wire logic                  mdc_i,
  input  wire logic                  mdio_i,
  input  wire logic                  mgmt_drive_i,
  input  wire logic                  mgmt_bit_i,
  output logic                       mdio_o,
  output logic                       mdio_oe_n_o,
  output logic                       mgmt_bit_o,
  output logic                       mgmt_strobe_o,
  output logic                       tx_clk_o,
  input  wire pmdp_pkg::pmdp_mac_tx_s mac_tx_i,
  output pmdp_pkg::pmdp_byte_s       tx_byte_o,
  output logic                       tx_end_o,
  output logic                       tx_frag_o,
  output logic                       rx_clk_o,
  output pmdp_pkg::pmdp_mac_rx_s     mac_rx_o,
  input  wire logic                  rx_frame_i,
  input  wire logic                  rx_false_carrier_i,
  input  wire pmdp_pkg::pmdp_byte_s  rx_byte_i,
  output logic                       rx_ready_o
);

  // ****************************************************************
  // Mode helpers
  // ****************************************************************

  // Bits carried per clock tick in each mode
  function automatic logic [3:0] unit_w(input pmdp_pkg::pmdp_mode_e m);
    unique case (m)
      pmdp_pkg::PMDP_MII10,
      pmdp_pkg::PMDP_MII100:  unit_w = 4'(`PMDP_W_MII);
      pmdp_pkg::PMDP_RMII10,
      pmdp_pkg::PMDP_RMII100: unit_w = 4'(`PMDP_W_RMII);
      default:                unit_w = 4'(`PMDP_W_SERIAL);
    endcase
  endfunction : unit_w
  // Half period of the port timing in system cycles
  function automatic logic [5:0] half_of(input pmdp_pkg::pmdp_mode_e m);
    unique case (m)
      pmdp_pkg::PMDP_MII10:   half_of = 6'(`PMDP_HALF_MII10);
      pmdp_pkg::PMDP_MII100:  half_of = 6'(`PMDP_HALF_MII100);
      pmdp_pkg::PMDP_RMII10:  half_of = 6'(`PMDP_HALF_RMII10);
      pmdp_pkg::PMDP_RMII100: half_of = 6'(`PMDP_HALF_RMII100);
      default:                half_of = 6'(`PMDP_HALF_SERIAL);
    endcase
  endfunction : half_of
  function automatic logic is_rmii(input pmdp_pkg::pmdp_mode_e m);
    is_rmii = (m == pmdp_pkg::PMDP_RMII10) || (m == pmdp_pkg::PMDP_RMII100);
  endfunction : is_rmii

  // ****************************************************************
  // Mode selection
  // ****************************************************************
  pmdp_pkg::pmdp_mode_e mode_q, mode_d;
  logic                 rmii;
  logic                 serial;
  logic [3:0]           w;
  logic [5:0]           half;
  // Mode followed while reset is high, frozen afterwards
  always_comb mode_d = reset_i ? mode_i : mode_q;
  // Mode register
  always_ff @(posedge clock_i) begin
    mode_q <= mode_d;
  end
  assign rmii   = is_rmii(mode_q);
  assign serial = (mode_q == pmdp_pkg::PMDP_SERIAL);
  assign w      = unit_w(mode_q);
  assign half   = half_of(mode_q);

  // ****************************************************************
  // Port clocks
  // ****************************************************************
  logic tx_rise;
  logic rx_rise, rx_fall;
  // Transmit clock, dropped to low in RMII
  pmdp_clkgen u_tx_clk (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .half_i  (half),
    .en_i    (~rmii),
    .clk_o   (tx_clk_o),
    .rise_o  (tx_rise),
    .fall_o  ()
  );
  // Receive clock, dropped to low in RMII
  pmdp_clkgen u_rx_clk (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .half_i  (half),
    .en_i    (~rmii),
    .clk_o   (rx_clk_o),
    .rise_o  (rx_rise),
    .fall_o  (rx_fall)
  );

  // ****************************************************************
  // Management data pin
  // ****************************************************************
  logic mdc_q;
  logic mdio_q, mdio_d;
  logic oe_n_q, oe_n_d;
  logic mbit_q, mbit_d;
  logic mstb_q, mstb_d;
  // Sample on management clock rise; release unless told to drive
  always_comb begin
    mdio_d = mgmt_bit_i;
    oe_n_d = ~mgmt_drive_i;
    mstb_d = mdc_i & ~mdc_q;
    mbit_d = mstb_d ? mdio_i : mbit_q;
  end
  // Management registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mdc_q  <= 1'b0;
      mdio_q <= 1'b0;
      oe_n_q <= 1'b1;
      mbit_q <= 1'b0;
      mstb_q <= 1'b0;
    end else begin
      mdc_q  <= mdc_i;
      mdio_q <= mdio_d;
      oe_n_q <= oe_n_d;
      mbit_q <= mbit_d;
      mstb_q <= mstb_d;
    end
  end
  assign mdio_o        = mdio_q;
  assign mdio_oe_n_o   = oe_n_q;
  assign mgmt_bit_o    = mbit_q;
  assign mgmt_strobe_o = mstb_q;

  // ****************************************************************
  // Transmit path
  // ****************************************************************
  logic                 tx_tick;
  logic [7:0]           tx_sh_q, tx_sh_d;
  logic [3:0]           tx_cnt_q, tx_cnt_d;
  logic                 tx_en_q, tx_en_d;
  logic                 tx_end_q, tx_end_d;
  logic                 tx_frag_q, tx_frag_d;
  pmdp_pkg::pmdp_byte_s tx_byte_q, tx_byte_d;
  assign tx_tick = tx_rise;
  // Gather units LSB first into bytes while transmit enable is high
  always_comb begin
    tx_sh_d   = tx_sh_q;
    tx_cnt_d  = tx_cnt_q;
    tx_en_d   = tx_en_q;
    tx_end_d  = 1'b0;
    tx_frag_d = tx_frag_q;
    tx_byte_d = '0;
    if (tx_tick) begin
      tx_en_d = mac_tx_i.en;
      if (mac_tx_i.en) begin
        if (w == 4'(`PMDP_W_MII)) begin
          tx_sh_d = {mac_tx_i.data, tx_sh_q[7:4]};
        end else if (w == 4'(`PMDP_W_RMII)) begin
          tx_sh_d = {mac_tx_i.data[1:0], tx_sh_q[7:2]};
        end else begin
          tx_sh_d = {mac_tx_i.data[0], tx_sh_q[7:1]};
        end
        tx_cnt_d = tx_cnt_q + w;
        if (tx_cnt_d == 4'(`PMDP_BYTE_BITS)) begin
          tx_cnt_d       = 4'h0;
          tx_byte_d.valid = 1'b1;
          tx_byte_d.data  = tx_sh_d;
        end
      end else if (tx_en_q) begin
        tx_end_d  = 1'b1;                 // Frame closed by enable low
        tx_frag_d = (tx_cnt_q != 4'h0);   // Leftover bits dropped
        tx_cnt_d  = 4'h0;
      end
    end
  end

  // Transmit registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tx_sh_q   <= 8'h00;
      tx_cnt_q  <= 4'h0;
      tx_en_q   <= 1'b0;
      tx_end_q  <= 1'b0;
      tx_frag_q <= 1'b0;
      tx_byte_q <= '0;
    end else begin
      tx_sh_q   <= tx_sh_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_en_q   <= tx_en_d;
      tx_end_q  <= tx_end_d;
      tx_frag_q <= tx_frag_d;
      tx_byte_q <= tx_byte_d;
    end
  end
  assign tx_byte_o = tx_byte_q;
  assign tx_end_o  = tx_end_q;
  assign tx_frag_o = tx_frag_q;

  // ****************************************************************
  // Receive path
  // ****************************************************************
  logic                   rx_launch;
  logic                   fast;
  logic [7:0]             rx_sh_q, rx_sh_d;
  logic [3:0]             rx_left_q, rx_left_d;
  logic                   rx_err_q, rx_err_d;
  logic                   rx_rdy_q, rx_rdy_d;
  pmdp_pkg::pmdp_mac_rx_s rx_pin_q, rx_pin_d;
  // RMII launches on reference timing, others on receive clock fall
  assign rx_launch = rmii ? rx_rise : rx_fall;
  assign fast = (mode_q == pmdp_pkg::PMDP_MII100) ||
                (mode_q == pmdp_pkg::PMDP_RMII100);
  // Serialise bytes LSB first, frame them, flag errors in the 100 modes only
  always_comb begin
    rx_sh_d   = rx_sh_q;
    rx_left_d = rx_left_q;
    rx_err_d  = rx_err_q;
    rx_pin_d  = rx_pin_q;
    if (rx_launch) begin
      rx_pin_d = '0;
      if (rx_left_q != 4'h0) begin
        rx_pin_d.crs = 1'b1;
        rx_pin_d.dv  = ~serial;
        rx_pin_d.er  = rx_err_q & fast;
        if (w == 4'(`PMDP_W_MII)) begin
          rx_pin_d.data = rx_sh_q[3:0];
        end else if (w == 4'(`PMDP_W_RMII)) begin
          rx_pin_d.data[1:0] = rx_pin_d.er ? `PMDP_RMII_ERR_CODE
                                           : rx_sh_q[1:0];
        end else begin
          rx_pin_d.data[0] = rx_sh_q[0];
        end
        rx_sh_d   = rx_sh_q >> w;
        rx_left_d = rx_left_q - w;
      end else if (rx_false_carrier_i && fast) begin
        rx_pin_d.crs  = 1'b1;
        rx_pin_d.er   = 1'b1;
        rx_pin_d.data = rmii ? {2'h0, `PMDP_RMII_FC_CODE}
                             : `PMDP_MII_FC_CODE;
      end else begin
        rx_pin_d.crs = rx_frame_i & ~serial;   // Serial carrier frames data
      end
    end
    rx_rdy_d = (rx_left_d == 4'h0);
    if (rx_rdy_q && rx_byte_i.valid && (rx_left_d == 4'h0)) begin
      rx_sh_d   = rx_byte_i.data;
      rx_left_d = 4'(`PMDP_BYTE_BITS);
      rx_err_d  = rx_byte_i.err;
      rx_rdy_d  = 1'b0;
    end
  end

  // Receive registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_sh_q   <= 8'h00;
      rx_left_q <= 4'h0;
      rx_err_q  <= 1'b0;
      rx_rdy_q  <= 1'b0;
      rx_pin_q  <= '0;
    end else begin
      rx_sh_q   <= rx_sh_d;
      rx_left_q <= rx_left_d;
      rx_err_q  <= rx_err_d;
      rx_rdy_q  <= rx_rdy_d;
      rx_pin_q  <= rx_pin_d;
    end
  end
  assign mac_rx_o   = rx_pin_q;
  assign rx_ready_o = rx_rdy_q;

endmodule : pmdp_data_port

// ===== rtl/pmdp_regs.svh
`ifndef PMDP_REGS_SVH
`define PMDP_REGS_SVH

// ****************************************************************
// Clock rates in kHz
// ****************************************************************
`define PMDP_SYS_KHZ        100000
`define PMDP_MII100_KHZ     25000
`define PMDP_MII10_KHZ      2500
`define PMDP_SERIAL_KHZ     10000
`define PMDP_RMII_REF_KHZ   50000
`define PMDP_MDC_MAX_KHZ    25000

// ****************************************************************
// Derived half periods in system clock cycles
// ****************************************************************
`define PMDP_HALF(k)        (`PMDP_SYS_KHZ / (2 * (k)))
`define PMDP_RMII10_REPEAT  10
`define PMDP_HALF_MII100    `PMDP_HALF(`PMDP_MII100_KHZ)
`define PMDP_HALF_MII10     `PMDP_HALF(`PMDP_MII10_KHZ)
`define PMDP_HALF_SERIAL    `PMDP_HALF(`PMDP_SERIAL_KHZ)
`define PMDP_HALF_RMII100   `PMDP_HALF(`PMDP_RMII_REF_KHZ)
`define PMDP_HALF_RMII10    (`PMDP_HALF_RMII100 * `PMDP_RMII10_REPEAT)

// ****************************************************************
// Data widths and line codes
// ****************************************************************
`define PMDP_BYTE_BITS      8
`define PMDP_W_MII          4
`define PMDP_W_RMII         2
`define PMDP_W_SERIAL       1
`define PMDP_MII_FC_CODE    4'he
`define PMDP_RMII_FC_CODE   2'h2
`define PMDP_RMII_ERR_CODE  2'h1

`endif

// ===== rtl/pmdp_pkg.sv
package pmdp_pkg;

  // ****************************************************************
  // Data port modes
  // ****************************************************************
  typedef enum logic [2:0] {
    PMDP_MII10,
    PMDP_MII100,
    PMDP_RMII10,
    PMDP_RMII100,
    PMDP_SERIAL
  } pmdp_mode_e;

  // ****************************************************************
  // Pin groups and internal byte stream
  // ****************************************************************
  typedef struct packed {
    logic       en;
    logic [3:0] data;
  } pmdp_mac_tx_s;

  typedef struct packed {
    logic       crs;
    logic       dv;
    logic       er;
    logic [3:0] data;
  } pmdp_mac_rx_s;

  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } pmdp_byte_s;

endpackage : pmdp_pkg

// ===== rtl/pmdp_clkgen.sv
`timescale 1ns/1ns
`include "pmdp_regs.svh"

module pmdp_clkgen (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic [5:0] half_i,
  input  wire logic       en_i,
  output logic            clk_o,
  output logic            rise_o,
  output logic            fall_o
);

  logic [5:0] cnt_q, cnt_d;
  logic       lvl_q, lvl_d;
  logic       out_q, out_d;
  logic       rise_q, rise_d;
  logic       fall_q, fall_d;

  // Divider toggles the level every half_i cycles
  always_comb begin
    cnt_d  = cnt_q + 6'h1;
    lvl_d  = lvl_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (cnt_q >= half_i - 6'h1) begin
      cnt_d  = 6'h0;
      lvl_d  = ~lvl_q;
      rise_d = ~lvl_q;
      fall_d = lvl_q;
    end
    out_d = lvl_d & en_i;   // Pin held low when unused
  end

  // Divider registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cnt_q  <= 6'h0;
      lvl_q  <= 1'b0;
      out_q  <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      lvl_q  <= lvl_d;
      out_q  <= out_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign clk_o  = out_q;
  assign rise_o = rise_q;
  assign fall_o = fall_q;

endmodule : pmdp_clkgen

// ===== verif/pmdp_data_port_props.sv
`timescale 1ns/1ns
module pmdp_data_port_props (
  input wire logic                   clock_i,
  input wire logic                   reset_i,
  input wire pmdp_pkg::pmdp_mode_e   mode_i,
  input wire logic                   mdc_i,
  input wire logic                   mdio_i,
  input wire logic                   mgmt_drive_i,
  input wire logic                   mdio_oe_n_o,
  input wire logic                   mgmt_bit_o,
  input wire logic                   mgmt_strobe_o,
  input wire logic                   tx_clk_o,
  input wire pmdp_pkg::pmdp_byte_s   tx_byte_o,
  input wire logic                   rx_clk_o,
  input wire pmdp_pkg::pmdp_mac_rx_s mac_rx_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic rmii;
  logic ser;
  logic m100;
  // Mode groups
  assign rmii = mode_i inside {pmdp_pkg::PMDP_RMII10, pmdp_pkg::PMDP_RMII100};
  assign ser  = mode_i == pmdp_pkg::PMDP_SERIAL;
  assign m100 = mode_i == pmdp_pkg::PMDP_MII100;
  // ****************************************************************
  // Clock pins
  // ****************************************************************
  property p_rmii_clk;
    rmii |-> !tx_clk_o && !rx_clk_o;
  endproperty
  a_rmii_clk: assert property (p_rmii_clk)
    else $error("clock pin toggles in reduced mode");
  property p_mii100_tx;
    m100 && $rose(tx_clk_o) |-> tx_clk_o[*2] ##1 !tx_clk_o[*2] ##1 tx_clk_o;
  endproperty
  a_mii100_tx: assert property (p_mii100_tx)
    else $error("fast nibble clock period wrong");
  property p_ser_tx;
    ser && $rose(tx_clk_o) |-> tx_clk_o[*5] ##1 !tx_clk_o[*5] ##1 tx_clk_o;
  endproperty
  a_ser_tx: assert property (p_ser_tx)
    else $error("serial transmit clock period wrong");
  property p_ser_rx;
    ser && $rose(rx_clk_o) |-> rx_clk_o[*5] ##1 !rx_clk_o[*5];
  endproperty
  a_ser_rx: assert property (p_ser_rx)
    else $error("serial receive clock period wrong");
  // ****************************************************************
  // Receive and transmit pins
  // ****************************************************************
  property p_ser_pins;
    ser |-> !mac_rx_o.dv && !mac_rx_o.er && mac_rx_o.data[3:1] == 3'h0;
  endproperty
  a_ser_pins: assert property (p_ser_pins)
    else $error("serial receive pins misused");
  property p_dv_crs;
    !ser && mac_rx_o.dv |-> mac_rx_o.crs;
  endproperty
  a_dv_crs: assert property (p_dv_crs)
    else $error("valid without carrier");
  property p_er_10;
    mode_i inside {pmdp_pkg::PMDP_MII10, pmdp_pkg::PMDP_RMII10}
      |-> !mac_rx_o.er;
  endproperty
  a_er_10: assert property (p_er_10)
    else $error("receive error at low speed");
  property p_tx_take;
    m100 && tx_byte_o.valid |-> $past(tx_clk_o) && !$past(tx_clk_o, 2)
      && !tx_byte_o.err;
  endproperty
  a_tx_take: assert property (p_tx_take)
    else $error("byte not tied to clock rise");
  // ****************************************************************
  // Management pins
  // ****************************************************************
  property p_mdio_oe;
    !$past(reset_i) |-> mdio_oe_n_o == !$past(mgmt_drive_i);
  endproperty
  a_mdio_oe: assert property (p_mdio_oe)
    else $error("data line enable wrong");
  property p_strobe;
    $rose(mdc_i) |=> mgmt_strobe_o && mgmt_bit_o == $past(mdio_i)
      ##1 !mgmt_strobe_o;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("management capture wrong");
endmodule : pmdp_data_port_props

bind pmdp_data_port pmdp_data_port_props u_props (.clock_i, .reset_i,
  .mode_i, .mdc_i, .mdio_i, .mgmt_drive_i, .mdio_oe_n_o, .mgmt_bit_o,
  .mgmt_strobe_o, .tx_clk_o, .tx_byte_o, .rx_clk_o, .mac_rx_o);

// ===== verif/pmdp_mac_model.sv
`timescale 1ns/1ns
module pmdp_mac_model (
  input  wire logic              clock_i,
  input  wire logic              rmii_i,
  input  wire logic              tx_clk_i,
  output pmdp_pkg::pmdp_mac_tx_s mac_tx_o
);
  logic clk_q = 1'b0;
  int   misses = 0;
  initial mac_tx_o = '0;
  // Previous level of the transmit clock
  always @(posedge clock_i) clk_q <= tx_clk_i;
  // Next launch edge: after the first low cycle of the transmit clock,
  // or every 2nd edge in RMII; a launch that never comes is counted
  task automatic next_launch();
    int i;
    logic hit;
    hit = 1'b0;
    for (i = 0; i < 100 && !hit; i++) begin
      @(posedge clock_i);
      hit = rmii_i ? (i == 1) : (clk_q && !tx_clk_i);
    end
    if (!hit) misses++;
  endtask : next_launch
  // Sends n units of w bits, low first, then drops the enable
  task automatic xmit(input logic [15:0] bits, input int n, input int w);
    int i;
    logic [3:0] d;
    for (i = 0; i <= n; i++) begin
      next_launch();
      d = 4'(bits >> (i * w)) & (4'hf >> (4 - w));
      // Idle lines no longer hold the last unit
      if (i < n) begin
        mac_tx_o <= {1'b1, d};
      end else begin
        mac_tx_o <= {1'b0, ~mac_tx_o.data};
      end
    end
  endtask : xmit
endmodule : pmdp_mac_model

// ===== verif/tb_phy_mac_side_data_port.sv
`timescale 1ns/1ns
module tb_phy_mac_side_data_port;
  logic                   clock_i = 1'b0;
  logic                   reset_i = 1'b1;
  pmdp_pkg::pmdp_mode_e   mode_i = pmdp_pkg::PMDP_MII100;
  logic                   mdc_i = 1'b0;
  logic                   mdio_i;
  logic                   mgmt_drive_i = 1'b0;
  logic                   mgmt_bit_i = 1'b0;
  logic                   mdio_o, mdio_oe_n_o, mgmt_bit_o, mgmt_strobe_o;
  logic                   tx_clk_o, tx_end_o, tx_frag_o, rx_clk_o;
  pmdp_pkg::pmdp_mac_tx_s mac_tx_i;
  pmdp_pkg::pmdp_byte_s   tx_byte_o;
  pmdp_pkg::pmdp_mac_rx_s mac_rx_o;
  logic                   rx_frame_i = 1'b0;
  logic                   rx_false_carrier_i = 1'b0;
  pmdp_pkg::pmdp_byte_s   rx_byte_i = '0;
  logic                   rx_ready_o, rmii;
  logic                   sta_drv = 1'b0;
  logic                   sta_bit = 1'b0;
  int                     errors = 0;
  int                     total_checks = 0;
  always #5 clock_i = ~clock_i;
  // Pulled-up data line: device, station, or idle high
  assign mdio_i = !mdio_oe_n_o ? mdio_o : (sta_drv ? sta_bit : 1'b1);
  assign rmii = mode_i inside {pmdp_pkg::PMDP_RMII10, pmdp_pkg::PMDP_RMII100};
  pmdp_data_port dut (.clock_i, .reset_i, .mode_i, .mdc_i, .mdio_i,
    .mgmt_drive_i, .mgmt_bit_i, .mdio_o, .mdio_oe_n_o, .mgmt_bit_o,
    .mgmt_strobe_o, .tx_clk_o, .mac_tx_i, .tx_byte_o, .tx_end_o, .tx_frag_o,
    .rx_clk_o, .mac_rx_o, .rx_frame_i, .rx_false_carrier_i, .rx_byte_i,
    .rx_ready_o);
  pmdp_mac_model mac (.clock_i, .rmii_i(rmii), .tx_clk_i(tx_clk_o),
    .mac_tx_o(mac_tx_i));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic do_reset(input pmdp_pkg::pmdp_mode_e m);
    @(posedge clock_i);
    reset_i <= 1'b1;
    mode_i  <= m;
    repeat (6) @(posedge clock_i);
    reset_i <= 1'b0;
  endtask : do_reset
  task automatic wait_cond(input int sel);
    int i;
    logic hit;
    hit = 1'b0;
    for (i = 0; i < 400 && !hit; i++) begin
      @(negedge clock_i);
      case (sel)
        0: hit = tx_byte_o.valid === 1'b1;
        1: hit = tx_end_o === 1'b1;
        2: hit = mac_rx_o.crs === 1'b1;
        3: hit = mgmt_strobe_o === 1'b1;
        default: hit = rx_ready_o === 1'b1;
      endcase
    end
    if (!hit) begin
      errors++;
      $display("ERROR t=%0t wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
      give_verdict();
    end
  endtask : wait_cond
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_mgmt();
    @(posedge clock_i);
    mgmt_drive_i <= 1'b1;
    mgmt_bit_i   <= 1'b1;
    @(posedge clock_i);
    @(negedge clock_i);
    chk(8'({mdio_oe_n_o, mdio_i}), 8'h1);
    @(posedge clock_i);
    mgmt_drive_i <= 1'b0;
    sta_drv      <= 1'b1;
    @(posedge clock_i);
    mdc_i <= 1'b1;
    wait_cond(3);
    chk(8'({mdio_oe_n_o, mgmt_bit_o}), 8'h2);
    @(posedge clock_i);
    mdc_i   <= 1'b0;
    sta_drv <= 1'b0;
  endtask : t_mgmt
  task automatic t_period(input logic rx, input int exp);
    int i, r[$];
    logic c, prev;
    prev = 1'b1;
    for (i = 0; i < 200 && r.size() < 2; i++) begin
      @(negedge clock_i);
      c = rx ? rx_clk_o : tx_clk_o;
      if (c && !prev) r.push_back(i);
      prev = c;
    end
    if (r.size() < 2) r = '{0, 0};
    chk(8'(r[1] - r[0]), 8'(exp));
  endtask : t_period
  task automatic t_tx(input pmdp_pkg::pmdp_mode_e m, input logic [15:0] bits,
                      input int n, input int w, input logic [7:0] exp,
                      input logic frag);
    do_reset(m);
    fork
      mac.xmit(bits, n, w);
      begin
        wait_cond(0);
        chk(tx_byte_o.data, exp);
      end
    join
    wait_cond(1);
    chk(8'(tx_frag_o), 8'(frag));
    chk(8'(mac.misses), 8'h0);
  endtask : t_tx
  task automatic t_rx(input pmdp_pkg::pmdp_mode_e m, input logic [9:0] b,
                      input logic [7:0] exp, input logic [7:0] mask);
    do_reset(m);
    fork
      begin
        @(posedge clock_i);
        rx_byte_i <= b;
        wait_cond(4);
        @(posedge clock_i);
        rx_byte_i <= '0;
      end
      begin
        wait_cond(2);
        chk({mac_rx_o.dv, mac_rx_o.er, 2'h0, mac_rx_o.data} & mask,
            exp);
      end
    join
  endtask : t_rx
  task automatic t_false_carrier(input pmdp_pkg::pmdp_mode_e m,
                                 input logic [7:0] exp,
                                 input logic [7:0] mask);
    do_reset(m);
    @(posedge clock_i);
    rx_false_carrier_i <= 1'b1;
    wait_cond(2);
    chk({mac_rx_o.dv, mac_rx_o.er, 2'h0, mac_rx_o.data} & mask,
        exp);
    @(posedge clock_i);
    rx_false_carrier_i <= 1'b0;
  endtask : t_false_carrier
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    do_reset(pmdp_pkg::PMDP_MII100);
    t_mgmt();
    do_reset(pmdp_pkg::PMDP_MII10);
    t_period(1'b0, 40);
    t_period(1'b1, 40);
    t_tx(pmdp_pkg::PMDP_MII100, 16'h005a, 3, 4, 8'h5a, 1'b1);
    t_tx(pmdp_pkg::PMDP_RMII100, 16'h00c6, 4, 2, 8'hc6, 1'b0);
    t_tx(pmdp_pkg::PMDP_SERIAL, 16'h003c, 8, 1, 8'h3c, 1'b0);
    t_rx(pmdp_pkg::PMDP_MII100, 10'h39c, 8'hcc, 8'hff);
    t_rx(pmdp_pkg::PMDP_MII10, 10'h39c, 8'h8c, 8'hff);
    t_rx(pmdp_pkg::PMDP_RMII100, 10'h24e, 8'h82, 8'hc3);
    t_rx(pmdp_pkg::PMDP_RMII100, 10'h34e, 8'hc1, 8'hc3);
    t_rx(pmdp_pkg::PMDP_RMII10, 10'h34e, 8'h82, 8'hc3);
    t_rx(pmdp_pkg::PMDP_SERIAL, 10'h201, 8'h01, 8'hff);
    t_false_carrier(pmdp_pkg::PMDP_RMII100, 8'h42, 8'hc3);
    t_false_carrier(pmdp_pkg::PMDP_MII100, 8'h4e, 8'hff);
    give_verdict();
  end
endmodule : tb_phy_mac_side_data_port
